//--- hw/cgl_pkg.sv
/*
 Shared constants for the channel-gain list sequencer.
 Assumes a single 250 MHz core clock.
*/
package cgl_pkg;
    localparam int          LIST_DEPTH      = 1024;
    localparam int          PTR_W           = 10;
    localparam int          CHAN_W          = 4;
    localparam int          GAIN_W          = 2;
    localparam int          ENTRY_W         = 7;
    localparam int          ENTRY_CHAN_LSB  = 0;
    localparam int          ENTRY_GAIN_LSB  = 4;
    localparam int          ENTRY_DIG_BIT   = 6;
    localparam logic [3:0]  MAX_CHAN_SE     = 4'hF;
    localparam logic [3:0]  MAX_CHAN_DIFF   = 4'h7;
    localparam int          SAMPLE_W        = 12;
    localparam int          DIG_W           = 16;
    localparam int          OUT_W           = 24;
    localparam int          DIV_W           = 24;
    localparam logic [23:0] DIV_RESET       = 24'h000001;
    localparam int          CORE_CLK_MHZ    = 250;
    localparam int          TBASE_MHZ       = 20;
    localparam int          TBASE_NUM       = TBASE_MHZ;
    localparam int          TBASE_DEN       = CORE_CLK_MHZ;
    localparam int          PASS_W          = 8;
    localparam logic [7:0]  PASS_RESET      = 8'h00;
    localparam int          FIFO_DEPTH      = 8;
    localparam logic [1:0]  GAIN_X1         = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_CONV = 2'b11,
        ST_WAIT = 2'b10
    } seq_state_e;
endpackage

//--- hw/stream_if.sv
/*
 Valid/ready stream carrier between the sequencer and its FIFO.
 Assumes both ends share the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 24);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- hw/sample_fifo.sv
/*
 Synchronous FIFO, parameterised width and depth.
 Assumes one clock; writes while full are dropped.
*/
`timescale 1ns/10ps
`default_nettype none
module sample_fifo
    import cgl_pkg::*;
#(
    parameter int WIDTH = OUT_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic             core_clk_in,
    input  wire logic             reset_in,
    stream_if.snk                 wr,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic [WIDTH-1:0]      rd_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr_q;
    logic [AW:0]      rptr_q;
    logic             full;
    logic             empty;

    assign empty = (wptr_q == rptr_q);
    assign full  = (wptr_q[AW-1:0] == rptr_q[AW-1:0]) && (wptr_q[AW] != rptr_q[AW]);
    assign wr.ready     = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out  = mem[rptr_q[AW-1:0]];

    always_ff @(posedge core_clk_in)
    begin
        if (wr.valid && !full)
        begin
            mem[wptr_q[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
        end
        else
        begin
            if (wr.valid && !full)
            begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (rd_ready_in && !empty)
            begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/adc_channel_gain_sequencer.sv
/*
 Channel-gain list sequencer: steps a loaded list once per pacing pulse,
 drives mux channel and amplifier gain, captures the converter result or
 sixteen digital lines, and queues tagged samples in an 8-word FIFO.
 Assumes the converter answers conv_done_in within the pacing period;
 the list is loaded only while the sequencer is idle.
*/
// How it works
// [R1] List holds up to 1024 channel-gain entries
// [R2] Entries visited strictly first through last
// [R3] Triggered scan repeats list up to 256 passes
// [R4] Any channel order, repeats and single allowed
// [R5] Channel limit 15 single-ended, 7 differential
// [R6] Samples always keep fixed 12-bit width; digital entries carry 16 lines instead
// [R7] Per-entry gain of 1, 2, 4, 8
// [R8] One range setting for whole subsystem
// [R9] Gain read with channel from same entry
// [R10] Channel 0 with modifier captures 16 lines
// [R11] Digital entries paced like analog ones
// [R12] Digital-only list reaches 3 MSamples/s
// [R13] Pacing from 24-bit divider or external pin
// [R14] One pacing pulse advances one entry
// [R15] Divider on 20 MHz base, low pulse, falling edge
// [R16] External pacing starts on falling edge
// [R17] Continuous scan wraps until host stops
// [R18] Arming clears pointer and pass counter
`timescale 1ns/10ps
`default_nettype none
module adc_channel_gain_sequencer
    import cgl_pkg::*;
(
    input  wire logic                core_clk_in,
    input  wire logic                reset_in,
    input  wire logic                load_we_in,
    input  wire logic [PTR_W-1:0]    load_addr_in,
    input  wire logic [ENTRY_W-1:0]  load_entry_in,
    input  wire logic [PTR_W:0]      list_len_in,
    input  wire logic                diff_mode_in,
    input  wire logic                bipolar_in,
    input  wire logic                ext_clk_sel_in,
    input  wire logic [DIV_W-1:0]    pace_div_in,
    input  wire logic                ext_pace_clk_in,
    input  wire logic                triggered_mode_in,
    input  wire logic [PASS_W-1:0]   pass_count_in,
    input  wire logic                arm_in,
    input  wire logic                stop_in,
    input  wire logic                trigger_in,
    input  wire logic [SAMPLE_W-1:0] conv_data_in,
    input  wire logic                conv_done_in,
    input  wire logic [DIG_W-1:0]    dig_lines_in,
    input  wire logic                sample_ready_in,
    output logic                     sample_valid_out,
    output logic [OUT_W-1:0]         sample_data_out,
    output logic [CHAN_W-1:0]        mux_chan_out,
    output logic [GAIN_W-1:0]        pga_gain_out,
    output logic                     bipolar_out,
    output logic                     conv_start_out,
    output logic                     pace_n_out,
    output logic                     running_out,
    output logic                     waiting_out,
    output logic                     chan_error_out,
    output logic                     overrun_out
);
    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic chan_ok(input logic [CHAN_W-1:0] ch, input logic diff);
        chan_ok = diff ? (ch <= MAX_CHAN_DIFF) : (ch <= MAX_CHAN_SE); // [R5]
    endfunction

    function automatic logic is_digital(input logic [ENTRY_W-1:0] e);
        is_digital = e[ENTRY_DIG_BIT] && (e[ENTRY_CHAN_LSB +: CHAN_W] == '0); // [R10]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // List storage

    logic [ENTRY_W-1:0] list_mem [LIST_DEPTH]; // [R1]
    logic [ENTRY_W-1:0] entry_q;
    logic [PTR_W-1:0]   ptr_q;
    logic [PASS_W-1:0]  pass_q;
    seq_state_e         state_q;

    always_ff @(posedge core_clk_in)
    begin
        if (load_we_in)
        begin
            list_mem[load_addr_in] <= load_entry_in; // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pacing: 20 MHz base enable, 24-bit divider, external pin sync

    logic [7:0]       tb_acc_q;
    logic             tb_tick;
    logic [DIV_W-1:0] div_q;
    logic             pace_n_q;
    logic             pace_n_prev_q;
    logic             ext_s1_q;
    logic             ext_s2_q;
    logic             ext_prev_q;
    logic             pace_pulse;

    // Fractional accumulator gives a 20 MHz average rate from 250 MHz
    assign tb_tick = (32'(tb_acc_q) + TBASE_NUM) >= TBASE_DEN;

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            tb_acc_q <= '0;
        end
        else if (tb_tick)
        begin
            tb_acc_q <= 8'(32'(tb_acc_q) + TBASE_NUM - TBASE_DEN); // [R15]
        end
        else
        begin
            tb_acc_q <= 8'(32'(tb_acc_q) + TBASE_NUM);
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in || state_q == ST_IDLE)
        begin
            div_q    <= DIV_RESET;
            pace_n_q <= 1'b1;
        end
        else if (tb_tick && div_q <= DIV_RESET)
        begin
            div_q    <= (pace_div_in == '0) ? DIV_RESET : pace_div_in; // [R13]
            pace_n_q <= 1'b0; // [R15]
        end
        else
        begin
            // One-cycle low pulse keeps an edge even at the top rate
            if (tb_tick)
            begin
                div_q <= div_q - 1'b1;
            end
            pace_n_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            ext_s1_q      <= 1'b1;
            ext_s2_q      <= 1'b1;
            ext_prev_q    <= 1'b1;
            pace_n_prev_q <= 1'b1;
        end
        else
        begin
            ext_s1_q      <= ext_pace_clk_in;
            ext_s2_q      <= ext_s1_q;
            ext_prev_q    <= ext_s2_q;
            pace_n_prev_q <= pace_n_q;
        end
    end

    // Falling edge of the selected source
    assign pace_pulse = ext_clk_sel_in ? (ext_prev_q && !ext_s2_q)           // [R16]
                                       : (pace_n_prev_q && !pace_n_q);      // [R13]

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    stream_if #(.WIDTH(OUT_W)) push ();
    logic             last_entry;
    logic             last_pass;
    logic             digital_q;

    assign last_entry = ({1'b0, ptr_q} + 1'b1) >= list_len_in;
    assign last_pass  = (pass_q >= pass_count_in);

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            state_q        <= ST_IDLE;
            ptr_q          <= '0;
            pass_q         <= PASS_RESET;
            entry_q        <= '0;
            digital_q      <= 1'b0;
            conv_start_out <= 1'b0;
            overrun_out    <= 1'b0;
        end
        else
        begin
            conv_start_out <= 1'b0;
            entry_q        <= list_mem[ptr_q]; // [R9]
            if (stop_in)
            begin
                state_q <= ST_IDLE; // [R17]
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        if (arm_in && list_len_in != '0)
                        begin
                            ptr_q       <= '0; // [R18]
                            pass_q      <= PASS_RESET; // [R18]
                            overrun_out <= 1'b0;
                            state_q     <= triggered_mode_in ? ST_WAIT : ST_RUN;
                        end
                    end
                    ST_WAIT:
                    begin
                        if (trigger_in)
                        begin
                            ptr_q   <= '0;
                            pass_q  <= PASS_RESET;
                            state_q <= ST_RUN;
                        end
                    end
                    ST_RUN:
                    begin
                        if (pace_pulse) // [R14]
                        begin
                            digital_q <= is_digital(entry_q); // [R11]
                            if (is_digital(entry_q))
                            begin
                                state_q <= ST_CONV; // [R12]
                            end
                            else
                            begin
                                conv_start_out <= 1'b1;
                                state_q        <= ST_CONV;
                            end
                        end
                    end
                    ST_CONV:
                    begin
                        if (pace_pulse)
                        begin
                            overrun_out <= 1'b1;
                        end
                        if (digital_q || conv_done_in)
                        begin
                            if (!push.ready)
                            begin
                                overrun_out <= 1'b1;
                            end
                            if (!last_entry)
                            begin
                                ptr_q   <= ptr_q + 1'b1; // [R2]
                                state_q <= ST_RUN;
                            end
                            else
                            begin
                                ptr_q <= '0; // [R17]
                                if (triggered_mode_in && last_pass)
                                begin
                                    pass_q  <= PASS_RESET;
                                    state_q <= ST_WAIT;
                                end
                                else
                                begin
                                    pass_q  <= triggered_mode_in ? pass_q + 1'b1 : pass_q; // [R3]
                                    state_q <= ST_RUN;
                                end
                            end
                        end
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Sample word: {dig flag, 1'b0, chan, gain, 16-bit payload}
    assign push.valid = (state_q == ST_CONV) && (digital_q || conv_done_in) && !stop_in;
    assign push.data  = digital_q
        ? {1'b1, 1'b0, entry_q[ENTRY_CHAN_LSB +: CHAN_W], entry_q[ENTRY_GAIN_LSB +: GAIN_W], dig_lines_in}
        : {1'b0, 1'b0, entry_q[ENTRY_CHAN_LSB +: CHAN_W], entry_q[ENTRY_GAIN_LSB +: GAIN_W],
           4'h0, conv_data_in}; // [R6]

    ////////////////////////////////////////////////////////////////////////
    // Converter front-end outputs

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            mux_chan_out   <= '0;
            pga_gain_out   <= GAIN_X1;
            bipolar_out    <= 1'b0;
            chan_error_out <= 1'b0;
            pace_n_out     <= 1'b1;
            running_out    <= 1'b0;
            waiting_out    <= 1'b0;
        end
        else
        begin
            mux_chan_out   <= entry_q[ENTRY_CHAN_LSB +: CHAN_W];
            pga_gain_out   <= entry_q[ENTRY_GAIN_LSB +: GAIN_W]; // [R7]
            bipolar_out    <= bipolar_in; // [R8]
            pace_n_out     <= ext_clk_sel_in ? ext_s2_q : pace_n_q;
            running_out    <= (state_q == ST_RUN) || (state_q == ST_CONV);
            waiting_out    <= (state_q == ST_WAIT);
            // Sticky until next arm; bad entries still convert
            if (state_q == ST_IDLE && arm_in)
            begin
                chan_error_out <= 1'b0;
            end
            else if (state_q == ST_RUN && pace_pulse && !chan_ok(entry_q[ENTRY_CHAN_LSB +: CHAN_W], diff_mode_in))
            begin
                chan_error_out <= 1'b1; // [R5]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output queue

    logic              q_valid;
    logic [OUT_W-1:0]  q_data;
    logic              take;

    sample_fifo #(.WIDTH(OUT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .wr           (push),
        .rd_valid_out (q_valid),
        .rd_ready_in  (take),
        .rd_data_out  (q_data)
    );

    // Registered skid stage so outputs come from flops
    assign take = q_valid && (!sample_valid_out || sample_ready_in);

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            sample_valid_out <= 1'b0;
            sample_data_out  <= '0;
        end
        else if (take)
        begin
            sample_valid_out <= 1'b1;
            sample_data_out  <= q_data;
        end
        else if (sample_ready_in)
        begin
            sample_valid_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- testbench/seq_properties.sv
/*
 Port-level timing checker for the channel-gain sequencer.
 Assumes the single core clock and the synchronous high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module seq_properties
    import cgl_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic              reset_in,
    input  wire logic              stop_in,
    input  wire logic              arm_in,
    input  wire logic              diff_mode_in,
    input  wire logic              bipolar_in,
    input  wire logic              ext_clk_sel_in,
    input  wire logic              sample_ready_in,
    input  wire logic              sample_valid_out,
    input  wire logic [OUT_W-1:0]  sample_data_out,
    input  wire logic [CHAN_W-1:0] mux_chan_out,
    input  wire logic [GAIN_W-1:0] pga_gain_out,
    input  wire logic              bipolar_out,
    input  wire logic              conv_start_out,
    input  wire logic              pace_n_out,
    input  wire logic              running_out,
    input  wire logic              waiting_out,
    input  wire logic              chan_error_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (reset_in);

sequence stalled;
    sample_valid_out && !sample_ready_in;
endsequence
sequence word_held;
    sample_valid_out && $stable(sample_data_out);
endsequence
sequence recent_pace;
    !pace_n_out || !$past(pace_n_out) || !$past(pace_n_out, 2);
endsequence

start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
    else $error("start strobe longer than one cycle");
held_word_a: assert property (stalled |=> word_held)
    else $error("queued word changed while stalled");
start_run_a: assert property (conv_start_out |-> running_out)
    else $error("conversion started while not running");
int_pace_a: assert property (conv_start_out && !ext_clk_sel_in |-> recent_pace)
    else $error("conversion not preceded by pace low");
chan_hold_a: assert property (conv_start_out |=> ($stable(mux_chan_out) && $stable(pga_gain_out))[*2])
    else $error("channel or gain moved during conversion");
err_sticky_a: assert property (chan_error_out && !arm_in |=> chan_error_out)
    else $error("channel error flag dropped");
diff_range_a: assert property (conv_start_out && diff_mode_in && mux_chan_out > MAX_CHAN_DIFF
    |-> ##[0:4] chan_error_out)
    else $error("differential channel overflow not flagged");
// Status outputs are registered from the state, one cycle behind it
stop_idle_a: assert property (stop_in |=> ##1 (!running_out && !waiting_out))
    else $error("stop did not return to idle");
wait_quiet_a: assert property (waiting_out |-> !conv_start_out)
    else $error("conversion while waiting for trigger");
range_follow_a: assert property ($stable(bipolar_in)[*3] |-> bipolar_out == bipolar_in)
    else $error("range output does not follow setting");
endmodule

bind adc_channel_gain_sequencer seq_properties chk (.*);
`default_nettype wire

//--- testbench/conv_model.sv
/*
 Behavioural converter on the sequencer's far side: answers each start
 with a running count after a bench-chosen delay. Assumes the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module conv_model
    import cgl_pkg::*;
(
    input  wire logic                core_clk_in,
    input  wire logic                start_in,
    input  wire logic [7:0]          delay_in,
    output logic                     done_out = 1'b0,
    output logic [SAMPLE_W-1:0]      data_out = 12'h000
);
logic [SAMPLE_W-1:0] count_q = 12'h000;
logic [7:0]          left_q  = 8'h00;

always @(posedge core_clk_in)
begin
    // Result lines carry junk outside the answer cycle
    done_out <= !start_in && left_q == 8'h01;
    data_out <= (!start_in && left_q == 8'h01) ? count_q : ~data_out;
    if (start_in)
    begin
        count_q <= count_q + 12'h001;
        left_q  <= delay_in;
    end
    else if (left_q != 8'h00)
    begin
        left_q <= left_q - 8'h01;
    end
end
endmodule
`default_nettype wire

//--- testbench/adc_channel_gain_sequencer_tb.sv
/*
 Self-checking bench for the channel-gain sequencer.
 Drives inputs at the falling edge; converter model on the far side.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_channel_gain_sequencer_tb
    import cgl_pkg::*;
;
logic core_clk_in = 1'b0, reset_in = 1'b1, load_we_in = 1'b0, diff_mode_in = 1'b0;
logic bipolar_in = 1'b0, ext_clk_sel_in = 1'b0, ext_pace_clk_in = 1'b1, arm_in = 1'b0;
logic triggered_mode_in = 1'b0, stop_in = 1'b0, trigger_in = 1'b0, sample_ready_in = 1'b0;
logic conv_done_in, stall_q = 1'b0;
logic [PTR_W-1:0]    load_addr_in  = 10'h000;
logic [ENTRY_W-1:0]  load_entry_in = 7'h00;
logic [PTR_W:0]      list_len_in   = 11'h000;
logic [DIV_W-1:0]    pace_div_in   = 24'h000008;
logic [PASS_W-1:0]   pass_count_in = 8'h00;
logic [SAMPLE_W-1:0] conv_data_in;
logic [DIG_W-1:0]    dig_lines_in  = 16'h0000;
logic sample_valid_out, bipolar_out, conv_start_out, pace_n_out;
logic running_out, waiting_out, chan_error_out, overrun_out;
logic [OUT_W-1:0]    sample_data_out;
logic [CHAN_W-1:0]   mux_chan_out;
logic [GAIN_W-1:0]   pga_gain_out;
logic [7:0]          delay_q = 8'h03;
logic [31:0]         rs_q    = 32'h00000045;
logic [11:0]         an_q;
logic [ENTRY_W-1:0]  lst [8];
logic [OUT_W-1:0]    got_q [$];
int bad_count = 0, tests_run = 0, cyc = 0;

adc_channel_gain_sequencer dut (.*);
conv_model conv (.core_clk_in(core_clk_in), .start_in(conv_start_out), .delay_in(delay_q),
    .done_out(conv_done_in), .data_out(conv_data_in));

initial forever #2 core_clk_in = ~core_clk_in;
// External pace pin: unrelated phase, idle high when not selected
always #149.3 ext_pace_clk_in = ext_clk_sel_in ? ~ext_pace_clk_in : 1'b1;
always @(negedge core_clk_in) sample_ready_in <= stall_q ? 1'b0 : ^rnd16();
always @(posedge core_clk_in)
    if (sample_valid_out === 1'b1 && sample_ready_in === 1'b1)
        got_q.push_back(sample_data_out);
////////////////////////////////////////////////////////////////////////
function automatic logic [15:0] rnd16();
    rs_q ^= rs_q << 13;
    rs_q ^= rs_q >> 17;
    rs_q ^= rs_q << 5;
    return rs_q[15:0];
endfunction

function automatic logic [OUT_W-1:0] exp_word(input logic [ENTRY_W-1:0] e, input logic [11:0] n);
    logic dig;
    dig = e[6] && (e[3:0] == 4'h0);
    return {dig, 1'b0, e[3:0], e[5:4], dig ? dig_lines_in : {4'h0, n}};
endfunction

task automatic check(input logic [OUT_W-1:0] exp, input logic [OUT_W-1:0] got, input string what);
    tests_run++;
    if (got !== exp)
    begin
        bad_count++;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
endtask

task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask

always @(posedge core_clk_in)
begin
    cyc++;
    if (cyc == 60000)
    begin
        bad_count++;
        stop_test();
    end
end
////////////////////////////////////////////////////////////////////////
task automatic pulse(ref logic s);
    @(negedge core_clk_in);
    s = 1'b1;
    @(negedge core_clk_in);
    s = 1'b0;
endtask

task automatic cmp(input int len, input int from, input int to);
    while (got_q.size() < to) @(posedge core_clk_in);
    for (int i = from; i < to; i++)
    begin
        if (!(lst[i % len][6] && lst[i % len][3:0] == 4'h0))
            an_q++;
        check(exp_word(lst[i % len], an_q), got_q[i], "sample");
    end
endtask

task automatic scan(input int len, input int n, input logic trig);
    for (int i = 0; i < len; i++)
    begin
        @(negedge core_clk_in);
        load_we_in = 1'b1;
        load_addr_in = i[PTR_W-1:0];
        load_entry_in = lst[i];
    end
    @(negedge core_clk_in);
    load_we_in = 1'b0;
    list_len_in = len[PTR_W:0];
    an_q = conv.count_q;
    pulse(arm_in);
    if (trig)
    begin
        repeat (20) @(negedge core_clk_in);
        check(1, waiting_out, "waiting");
        pulse(trigger_in);
    end
    cmp(len, 0, n);
endtask

task automatic halt();
    pulse(stop_in);
    stall_q = 1'b0;
    repeat (150) @(negedge core_clk_in);
    got_q.delete();
endtask
////////////////////////////////////////////////////////////////////////
initial
begin
    logic [15:0] r;
    repeat (6) @(negedge core_clk_in);
    reset_in = 1'b0;
    @(negedge core_clk_in);
    check(1, pace_n_out, "pace idle");
    check(0, running_out, "running");
    check(0, sample_valid_out, "valid");
    dig_lines_in = rnd16();
    // Digital entry first, all gain codes, top channel last
    for (int i = 0; i < 5; i++)
    begin
        r = rnd16();
        lst[i] = {i == 0, i[1:0], i == 0 ? 4'h0 : (i == 4 ? 4'hF : r[3:0])};
    end
    scan(5, 12, 1'b0);
    check(0, chan_error_out, "chan error");
    check(0, overrun_out, "overrun");
    halt();
    delay_q = 8'h28;
    scan(5, 7, 1'b0);
    halt();
    // Lone digital entry at the fastest pace
    lst[0] = 7'h40;
    pace_div_in = 24'h000001;
    scan(1, 8, 1'b0);
    halt();
    pace_div_in = 24'h000008;
    delay_q = 8'h03;
    triggered_mode_in = 1'b1;
    pass_count_in = 8'h01;
    lst[2] = lst[1];
    scan(3, 6, 1'b1);
    repeat (400) @(negedge core_clk_in);
    check(6, 24'(got_q.size()), "pass count");
    check(1, waiting_out, "waiting");
    pulse(trigger_in);
    cmp(3, 6, 12);
    halt();
    triggered_mode_in = 1'b0;
    // Channel nine in differential mode is flagged but still sampled
    diff_mode_in = 1'b1;
    lst[0] = 7'h19;
    scan(1, 2, 1'b0);
    check(1, chan_error_out, "chan error");
    check(9, mux_chan_out, "mux channel");
    check(1, pga_gain_out, "gain");
    halt();
    diff_mode_in = 1'b0;
    ext_clk_sel_in = 1'b1;
    bipolar_in = 1'b1;
    scan(3, 4, 1'b0);
    check(1, bipolar_out, "range");
    halt();
    ext_clk_sel_in = 1'b0;
    // Stalled consumer: queue fills, then refuses
    stall_q = 1'b1;
    pace_div_in = 24'h000001;
    pulse(arm_in);
    for (int k = 0; k < 400 && overrun_out !== 1'b1; k++) @(negedge core_clk_in);
    check(1, overrun_out, "overrun");
    pulse(stop_in);
    stall_q = 1'b0;
    repeat (100) @(negedge core_clk_in);
    // Queue depth plus the output register's word
    check(FIFO_DEPTH + 1, 24'(got_q.size()), "drained");
    stop_test();
end
endmodule
`default_nettype wire
